// File: hw/prs_pkg.sv
// Package: constants and types of the preset rail sequencer
package prs_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 40_000_000;
  localparam int unsigned STEP_DELAY_MS = 7;
  localparam int unsigned PERSIST_MS    = 100;
  localparam int unsigned STEP_CYCLES    = CLK_HZ / 1000 * STEP_DELAY_MS;
  localparam int unsigned PERSIST_CYCLES = CLK_HZ / 1000 * PERSIST_MS;
  localparam int unsigned TIMER_W        = 23;

  // ----------------------------------------------------------------
  // Channel indices inside the four-bit sequenced vector
  // ----------------------------------------------------------------
  localparam int unsigned CH1 = 0;
  localparam int unsigned CH2 = 1;
  localparam int unsigned CH3 = 2;
  localparam int unsigned CH4 = 3;
  localparam int unsigned NUM_SEQ_CH = 4;

  // ----------------------------------------------------------------
  // Interrupt status bits
  // ----------------------------------------------------------------
  localparam int unsigned IRQ_SHUTDOWN = 0;
  localparam int unsigned IRQ_UVLO     = 1;
  localparam int unsigned IRQ_ON_DONE  = 2;
  localparam int unsigned IRQ_OFF_DONE = 3;
  localparam int unsigned IRQ_W        = 4;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_MASK   = 8'h04;
  localparam logic [7:0] REG_STATE  = 8'h08;
  localparam logic [3:0] MASK_RESET = 4'h0;

  // ----------------------------------------------------------------
  // Sequencer states, Gray from idle through off4; the return from off4 to idle flips two bits
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    SQ_IDLE  = 4'h0,
    SQ_ON1   = 4'h1,
    SQ_ON2   = 4'h3,
    SQ_ON3   = 4'h2,
    SQ_UP    = 4'h6,
    SQ_OFF1  = 4'h7,
    SQ_OFF2  = 4'h5,
    SQ_OFF3  = 4'h4,
    SQ_OFF4  = 4'hc
  } prs_state_t;

endpackage : prs_pkg

// File: hw/prs_sync.sv
// Two-flop synchroniser for a vector of pin inputs
`timescale 1ns/1ps
module prs_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] syncOut
);

  logic [W-1:0] meta_q;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      meta_q  <= '0;
      syncOut <= '0;
    end else begin
      meta_q  <= asyncIn;
      syncOut <= meta_q;
    end
  end

endmodule : prs_sync

// File: hw/prs_persist.sv
// Fault persistence timer: fires once a flag has held for LIMIT cycles
`timescale 1ns/1ps
module prs_persist #(
  parameter int unsigned LIMIT = 4_000_000
) (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic faultIn,
  output logic      expired
);

  logic [prs_pkg::TIMER_W-1:0] cnt_q;

  // ----------------------------------------------------------------
  // Counter restarts whenever the flag drops
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n || !faultIn) begin
      cnt_q <= '0;
    end else if (cnt_q != prs_pkg::TIMER_W'(LIMIT - 1)) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  assign expired = faultIn && (cnt_q == prs_pkg::TIMER_W'(LIMIT - 1));

endmodule : prs_persist

// File: hw/prs_sequencer.sv
// Top: preset rail sequencer with fault monitor and APB status registers
//
// What this block does
// - Sequence select low: each channel follows its own enable pin.
// - Select high, both order pins high: trigger runs order one; LDO independent.
// - Order one on: ch1 at once, then ch3, ch4, ch2, 7ms apart.
// - Order one off: ch2, then ch4, ch3, ch1, each after feedback low.
// - Select high, order A low, B high: trigger runs order two.
// - Order two on: ch1 first, then ch4, ch3, ch2, 7ms apart.
// - Order two off: ch2, then ch3, ch4, ch1, each after feedback low.
// - Order one shutdown completes only when feedback one falls low.
// - Ch1 boost current limit persisting 100ms shuts the IC down.
// - Ch1 undervoltage persisting 100ms shuts the IC down.
// - Ch1 output overvoltage shuts the IC down at once.
// - Ch2 boost current limit persisting 100ms shuts the IC down.
// - Ch2 undervoltage persisting 100ms shuts the IC down.
// - Battery undervoltage lockout disables all channels at once.
`timescale 1ns/1ps
module prs_sequencer #(
  parameter int unsigned STEP_CYCLES    = prs_pkg::STEP_CYCLES,
  parameter int unsigned PERSIST_CYCLES = prs_pkg::PERSIST_CYCLES
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        sequence_select,
  input  wire logic        boost1_enable,
  input  wire logic        sequence_trigger,
  input  wire logic        order_select_a,
  input  wire logic        order_select_b,
  input  wire logic        ldo_enable,
  input  wire logic        ch1FbLow,
  input  wire logic        ch2FbLow,
  input  wire logic        ch3FbLow,
  input  wire logic        ch4FbLow,
  input  wire logic        ch1CurLimit,
  input  wire logic        ch1UnderVolt,
  input  wire logic        ch1OverVolt,
  input  wire logic        ch2CurLimit,
  input  wire logic        ch2UnderVolt,
  input  wire logic        batUvlo,
  output logic             ch1Enable,
  output logic             ch2Enable,
  output logic             ch3Enable,
  output logic             ch4Enable,
  output logic             ch5Enable,
  output logic             ch1Discharge,
  output logic             ch2Discharge,
  output logic             ch3Discharge,
  output logic             ch4Discharge,
  output logic             icShutdown,
  output logic             irq,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  localparam int unsigned NPIN = 17;
  logic [NPIN-1:0] pinRaw;
  logic [NPIN-1:0] pinSync;

  assign pinRaw = {batUvlo, ch2UnderVolt, ch2CurLimit, ch1OverVolt, ch1UnderVolt,
                   ch1CurLimit, ch4FbLow, ch3FbLow, ch2FbLow, ch1FbLow, ldo_enable,
                   order_select_b, order_select_a, sequence_trigger, boost1_enable,
                   sequence_select, 1'b0};

  prs_sync #(.W(NPIN)) u_sync (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .asyncIn (pinRaw),
    .syncOut (pinSync)
  );

  logic seqSel, en1, trig, ordA, ordB, en5;
  logic [3:0] fbLow;
  logic cl1, uv1, ov1, cl2, uv2, uvlo;
  assign {uvlo, uv2, cl2, ov1, uv1, cl1} = pinSync[16:11];
  assign fbLow = pinSync[10:7];
  assign {en5, ordB, ordA, trig, en1, seqSel} = pinSync[6:1];

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  wire presetOne = seqSel && ordA && ordB;
  wire presetTwo = seqSel && !ordA && ordB;
  wire presetOn  = presetOne || presetTwo;

  // Step order as channel indices; off order reverses the on order
  function automatic logic [1:0] onChan(input logic one, input logic [1:0] step);
    logic [1:0] r;
    r = 2'(prs_pkg::CH1);
    case (step)
      2'd0: r = 2'(prs_pkg::CH1);
      2'd1: r = one ? 2'(prs_pkg::CH3) : 2'(prs_pkg::CH4);
      2'd2: r = one ? 2'(prs_pkg::CH4) : 2'(prs_pkg::CH3);
      default: r = 2'(prs_pkg::CH2);
    endcase
    return r;
  endfunction : onChan

  // ----------------------------------------------------------------
  // Fault monitor
  // ----------------------------------------------------------------
  logic cl1Exp, uv1Exp, cl2Exp, uv2Exp;

  prs_persist #(.LIMIT(PERSIST_CYCLES)) u_cl1 (
    .sys_clk (sys_clk), .rst_n (rst_n), .faultIn (cl1), .expired (cl1Exp));
  prs_persist #(.LIMIT(PERSIST_CYCLES)) u_uv1 (
    .sys_clk (sys_clk), .rst_n (rst_n), .faultIn (uv1), .expired (uv1Exp));
  prs_persist #(.LIMIT(PERSIST_CYCLES)) u_cl2 (
    .sys_clk (sys_clk), .rst_n (rst_n), .faultIn (cl2), .expired (cl2Exp));
  prs_persist #(.LIMIT(PERSIST_CYCLES)) u_uv2 (
    .sys_clk (sys_clk), .rst_n (rst_n), .faultIn (uv2), .expired (uv2Exp));

  wire shutdownEvt = cl1Exp || uv1Exp || cl2Exp || uv2Exp || ov1;

  // Latched shutdown; released once trigger, boost1 enable and LDO enable pins all read low
  logic       shut_q;
  logic [5:0] inPrev_q;
  wire  [5:0] inNow = {seqSel, en1, trig, ordA, ordB, en5};
  wire        allInLow = !trig && !en1 && !en5;
  wire        release_ = shut_q && allInLow && (inPrev_q != inNow || !seqSel || !trig);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      shut_q   <= 1'b0;
      inPrev_q <= '0;
    end else begin
      inPrev_q <= inNow;
      if (shutdownEvt) begin
        shut_q <= 1'b1;
      end else if (release_) begin
        shut_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Preset sequencer
  // ----------------------------------------------------------------
  prs_pkg::prs_state_t state_q, state_d;
  logic [prs_pkg::TIMER_W-1:0] tmr_q;
  logic       orderOne_q;
  logic [3:0] on_q, on_d;
  logic       trigPrev_q;

  wire trigRise = trig && !trigPrev_q;
  wire stepDone = (tmr_q == prs_pkg::TIMER_W'(STEP_CYCLES - 1));
  logic [1:0] offIdx;
  logic       onDone, offDone;

  always_comb begin
    state_d = state_q;
    on_d    = on_q;
    onDone  = 1'b0;
    offDone = 1'b0;
    offIdx  = 2'd0;
    case (state_q)
      prs_pkg::SQ_IDLE: begin
        if (presetOn && trigRise) begin
          on_d[prs_pkg::CH1] = 1'b1;
          state_d = prs_pkg::SQ_ON1;
        end
      end
      prs_pkg::SQ_ON1, prs_pkg::SQ_ON2, prs_pkg::SQ_ON3: begin
        if (!trig) begin
          state_d = prs_pkg::SQ_OFF1;
        end else if (stepDone) begin
          case (state_q)
            prs_pkg::SQ_ON1: begin
              on_d[onChan(orderOne_q, 2'd1)] = 1'b1;
              state_d = prs_pkg::SQ_ON2;
            end
            prs_pkg::SQ_ON2: begin
              on_d[onChan(orderOne_q, 2'd2)] = 1'b1;
              state_d = prs_pkg::SQ_ON3;
            end
            default: begin
              on_d[onChan(orderOne_q, 2'd3)] = 1'b1;
              onDone  = 1'b1;
              state_d = prs_pkg::SQ_UP;
            end
          endcase
        end
      end
      prs_pkg::SQ_UP: begin
        if (!trig) begin
          state_d = prs_pkg::SQ_OFF1;
        end
      end
      prs_pkg::SQ_OFF1: begin
        on_d[prs_pkg::CH2] = 1'b0;
        offIdx = 2'(prs_pkg::CH2);
        // Feedback alone gates each step; a rail never powered already reads low
        if (fbLow[offIdx]) begin
          state_d = prs_pkg::SQ_OFF2;
        end
      end
      prs_pkg::SQ_OFF2: begin
        offIdx = onChan(orderOne_q, 2'd2);
        on_d[offIdx] = 1'b0;
        if (fbLow[offIdx]) begin
          state_d = prs_pkg::SQ_OFF3;
        end
      end
      prs_pkg::SQ_OFF3: begin
        offIdx = onChan(orderOne_q, 2'd1);
        on_d[offIdx] = 1'b0;
        if (fbLow[offIdx]) begin
          state_d = prs_pkg::SQ_OFF4;
        end
      end
      prs_pkg::SQ_OFF4: begin
        on_d[prs_pkg::CH1] = 1'b0;
        offIdx = 2'(prs_pkg::CH1);
        if (fbLow[offIdx]) begin
          offDone = 1'b1;
          state_d = prs_pkg::SQ_IDLE;
        end
      end
      default: state_d = prs_pkg::SQ_IDLE;
    endcase
  end

  // Turn-off walk settles one stage before the next is cut
  always_ff @(posedge sys_clk) begin
    if (!rst_n || !presetOn || shut_q) begin
      state_q <= prs_pkg::SQ_IDLE;
      on_q    <= '0;
      tmr_q   <= '0;
    end else begin
      state_q <= state_d;
      on_q    <= on_d;
      tmr_q   <= (state_d != state_q) ? '0 : tmr_q + 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      trigPrev_q <= 1'b0;
      orderOne_q <= 1'b0;
    end else begin
      trigPrev_q <= trig;
      if (state_q == prs_pkg::SQ_IDLE) begin
        orderOne_q <= presetOne;
      end
    end
  end

  // ----------------------------------------------------------------
  // Channel outputs
  // ----------------------------------------------------------------
  wire kill = shut_q || uvlo;
  logic [3:0] chEn_d;
  // Independent mode maps each pin to its own channel
  assign chEn_d = !seqSel ? {ordB, ordA, trig, en1} :
                  presetOn ? on_q : 4'h0;
  wire ch5En_d = seqSel ? en5 : en5;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      {ch4Enable, ch3Enable, ch2Enable, ch1Enable} <= '0;
      ch5Enable <= 1'b0;
      {ch4Discharge, ch3Discharge, ch2Discharge, ch1Discharge} <= '0;
      icShutdown <= 1'b0;
    end else begin
      {ch4Enable, ch3Enable, ch2Enable, ch1Enable} <= kill ? 4'h0 : chEn_d;
      ch5Enable <= kill ? 1'b0 : ch5En_d;
      {ch4Discharge, ch3Discharge, ch2Discharge, ch1Discharge} <= kill ? 4'hf : ~chEn_d;
      icShutdown <= shut_q;
    end
  end

  // ----------------------------------------------------------------
  // Interrupts and APB slave
  // ----------------------------------------------------------------
  logic [prs_pkg::IRQ_W-1:0] stat_q, mask_q, evt;
  logic                      uvloPrev_q;

  assign evt[prs_pkg::IRQ_SHUTDOWN] = shutdownEvt && !shut_q;
  assign evt[prs_pkg::IRQ_UVLO]     = uvlo && !uvloPrev_q;
  assign evt[prs_pkg::IRQ_ON_DONE]  = onDone && !shut_q;
  assign evt[prs_pkg::IRQ_OFF_DONE] = offDone && !shut_q;

  wire apbWr  = psel && penable && pwrite;
  wire hitSt  = (paddr == prs_pkg::REG_STATUS);
  wire hitMk  = (paddr == prs_pkg::REG_MASK);
  wire hitSq  = (paddr == prs_pkg::REG_STATE);
  wire mapped = hitSt || hitMk || hitSq;
  wire [3:0] w1c = (apbWr && hitSt) ? pwdata[prs_pkg::IRQ_W-1:0] : 4'h0;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      stat_q     <= '0;
      mask_q     <= prs_pkg::MASK_RESET;
      uvloPrev_q <= 1'b0;
    end else begin
      uvloPrev_q <= uvlo;
      stat_q     <= (stat_q & ~w1c) | evt;
      if (apbWr && hitMk) begin
        mask_q <= pwdata[prs_pkg::IRQ_W-1:0];
      end
    end
  end

  assign irq     = |(stat_q & mask_q);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata  = !(psel && !pwrite) ? 32'h0 :
                   hitSt ? {28'h0, stat_q} :
                   hitMk ? {28'h0, mask_q} :
                   hitSq ? {22'h0, shut_q, uvlo, on_q, state_q} : 32'h0;

endmodule : prs_sequencer

// File: tb/prs_rail_model.sv
// Rail model: feedback comparators that read low a while after a rail turns off
`timescale 1ns/1ps
module prs_rail_model #(
  parameter int unsigned FAST = 10,
  parameter int unsigned SLOW = 40
) (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       slow,
  input  wire logic [3:0] railOn,
  output logic      [3:0] fbLow
);
  logic [7:0] age_q [4];
  for (genvar i = 0; i < 4; i++) begin : g_rail
    // A live rail never reads low; decay stands in for output charge
    assign fbLow[i] = !railOn[i] && (age_q[i] >= (slow ? SLOW : FAST));
    always_ff @(posedge sys_clk) begin
      if (!rst_n || railOn[i]) age_q[i] <= 8'h00;
      else if (age_q[i] != 8'hff) age_q[i] <= age_q[i] + 8'h01;
    end
  end
endmodule : prs_rail_model

// File: tb/prs_sequencer_monitor.sv
// Checker: sequencing and fault relations at the sequencer ports
`timescale 1ns/1ps
module prs_sequencer_monitor #(
  parameter int unsigned STEP_CYCLES    = 20,
  parameter int unsigned PERSIST_CYCLES = 50
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic sequence_select,
  input wire logic order_select_a,
  input wire logic order_select_b,
  input wire logic ldo_enable,
  input wire logic ch1CurLimit,
  input wire logic ch1OverVolt,
  input wire logic batUvlo,
  input wire logic ch1Enable,
  input wire logic ch2Enable,
  input wire logic ch3Enable,
  input wire logic ch4Enable,
  input wire logic ch5Enable,
  input wire logic icShutdown
);
  logic [3:0] onV;
  logic [3:0] prev_q;
  logic       late;
  logic       calm;
  logic       seqOne;
  logic       seqTwo;
  int         gap_q;
  int         cl_q;
  assign onV    = {ch4Enable, ch3Enable, ch2Enable, ch1Enable};
  assign late   = |(onV[3:1] & ~prev_q[3:1]);
  assign calm   = !icShutdown && !batUvlo;
  assign seqOne = sequence_select && order_select_a && order_select_b;
  assign seqTwo = sequence_select && !order_select_a && order_select_b;
  // ----------
  // Helpers
  // ----------
  // Gap restarts on any new rail, so it spans exactly one step
  always_ff @(posedge sys_clk) begin
    prev_q <= rst_n ? onV : 4'h0;
    gap_q  <= (|(onV & ~prev_q)) ? 1 : gap_q + 1;
    cl_q   <= (!rst_n || !ch1CurLimit) ? 0 : cl_q + 1;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // ----------
  // Assertions
  // ----------
  a_ovp_quick: assert property (ch1OverVolt |-> ##[1:5] icShutdown)
    else $error("overvoltage not shut down");
  a_uvlo_off: assert property (batUvlo [*5] |-> onV == 4'h0 && !ch5Enable)
    else $error("rail on under battery lockout");
  a_sd_off: assert property (icShutdown && $past(icShutdown) |-> onV == 4'h0 && !ch5Enable)
    else $error("rail on after shutdown");
  a_persist_fire: assert property (cl_q == PERSIST_CYCLES + 6 |-> ##[0:3] icShutdown)
    else $error("persistent fault not shut down");
  a_step_gap: assert property (sequence_select && late |->
    gap_q >= STEP_CYCLES - 1 && gap_q <= STEP_CYCLES + 1)
    else $error("step spacing wrong");
  a_order_one: assert property (seqOne && $rose(ch3Enable) |->
    ch1Enable && !ch4Enable && !ch2Enable) else $error("order one on wrong");
  a_order_two: assert property (seqTwo && $rose(ch4Enable) |->
    ch1Enable && !ch3Enable && !ch2Enable) else $error("order two on wrong");
  a_off_one: assert property (seqOne && calm && $fell(ch4Enable) |->
    ch3Enable && ch1Enable && !ch2Enable) else $error("order one off wrong");
  a_off_two: assert property (seqTwo && calm && $fell(ch3Enable) |->
    ch4Enable && ch1Enable && !ch2Enable) else $error("order two off wrong");
  a_ldo_indep: assert property ((ldo_enable && calm) [*5] |-> ch5Enable)
    else $error("ldo not independent");
  c_shutdown: cover property ($rose(icShutdown));
  c_order_two: cover property (seqTwo && late);
  c_off_one: cover property (seqOne && $fell(ch1Enable));
endmodule : prs_sequencer_monitor

bind prs_sequencer prs_sequencer_monitor #(
  .STEP_CYCLES(STEP_CYCLES),
  .PERSIST_CYCLES(PERSIST_CYCLES)
) mon_u (
  .sys_clk         (sys_clk),
  .rst_n           (rst_n),
  .sequence_select (sequence_select),
  .order_select_a  (order_select_a),
  .order_select_b  (order_select_b),
  .ldo_enable      (ldo_enable),
  .ch1CurLimit     (ch1CurLimit),
  .ch1OverVolt     (ch1OverVolt),
  .batUvlo         (batUvlo),
  .ch1Enable       (ch1Enable),
  .ch2Enable       (ch2Enable),
  .ch3Enable       (ch3Enable),
  .ch4Enable       (ch4Enable),
  .ch5Enable       (ch5Enable),
  .icShutdown      (icShutdown)
);

// File: tb/prs_sequencer_test.sv
// Testbench: pin sequencing, faults and APB status access
`timescale 1ns/1ps
module prs_sequencer_test;
  localparam int unsigned STEP = 20;
  localparam int unsigned PERS = 50;
  localparam int unsigned FAST = 10;
  localparam int unsigned SLOW = 40;
  logic        sys_clk = 1'b0, rst_n = 1'b0, sel = 1'b0, en1 = 1'b0, trig = 1'b0;
  logic        oa = 1'b0, ob = 1'b0, ldo = 1'b0, battery_input = 1'b0, slow = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, sd, irq, pready, err;
  logic [4:0]  pf = 5'h00, en;
  logic [3:0]  fbLow, dis;
  logic        rdErr;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  int          err_count = 0, n_checks = 0, n;
  logic [3:0]  ordA [4] = '{4'h1, 4'h5, 4'hd, 4'hf};
  logic [3:0]  ordB [4] = '{4'h1, 4'h9, 4'hd, 4'hf};
  always #12.5 sys_clk = ~sys_clk;
  prs_sequencer #(.STEP_CYCLES(STEP), .PERSIST_CYCLES(PERS)) dut_u (
    .sys_clk(sys_clk), .rst_n(rst_n), .sequence_select(sel), .boost1_enable(en1),
    .sequence_trigger(trig), .order_select_a(oa), .order_select_b(ob), .ldo_enable(ldo),
    .ch1FbLow(fbLow[0]), .ch2FbLow(fbLow[1]), .ch3FbLow(fbLow[2]), .ch4FbLow(fbLow[3]),
    .ch1CurLimit(pf[0]), .ch1UnderVolt(pf[1]), .ch2CurLimit(pf[2]),
    .ch2UnderVolt(pf[3]), .ch1OverVolt(pf[4]), .batUvlo(battery_input),
    .ch1Enable(en[0]), .ch2Enable(en[1]), .ch3Enable(en[2]), .ch4Enable(en[3]),
    .ch5Enable(en[4]), .ch1Discharge(dis[0]), .ch2Discharge(dis[1]),
    .ch3Discharge(dis[2]), .ch4Discharge(dis[3]), .icShutdown(sd), .irq(irq),
    .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(err));
  prs_rail_model #(.FAST(FAST), .SLOW(SLOW)) rail_u (.sys_clk(sys_clk), .rst_n(rst_n), .slow(slow),
    .railOn(en[3:0]), .fbLow(fbLow));
  // ----------
  // Tasks
  // ----------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk);
  endtask : cyc
  // One transfer; the extra edge keeps psel from two writes in one step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int w;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    w = 0;
    do begin
      @(posedge sys_clk);
      w++;
    end while (pready !== 1'b1 && w < 50);
    rd = prdata;
    rdErr = err;
    chk("pready", w < 50, 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : apb
  task automatic waitOn(input logic [3:0] v);
    n = 0;
    while (en[3:0] !== v && n < 200) begin
      @(posedge sys_clk);
      n++;
    end
    chk("rails", en[3:0], v);
  endtask : waitOn
  task automatic runSeq(input logic a, input logic [3:0] v [4]);
    sel <= 1'b1;
    oa <= a;
    ob <= 1'b1;
    ldo <= 1'b1;
    slow <= !a;
    apb(1'b1, prs_pkg::REG_STATUS, 32'hf);
    apb(1'b1, prs_pkg::REG_MASK, 32'h8);
    trig <= 1'b1;
    foreach (v[i]) begin
      waitOn(v[i]);
      if (i > 0) chk("step gap", n >= STEP - 1 && n <= STEP + 1, 1'b1);
    end
    chk("ldo", en[4], 1'b1);
    chk("discharge on", dis, 4'h0);
    trig <= 1'b0;
    for (int i = 2; i >= 0; i--) begin
      waitOn(v[i]);
      if (i < 2) chk("fb wait", n >= (a ? FAST : SLOW), 1'b1);
    end
    waitOn(4'h0);
    chk("fb wait", n >= (a ? FAST : SLOW), 1'b1);
    chk("discharge off", dis, 4'hf);
    apb(1'b0, prs_pkg::REG_STATUS, 32'h0);
    chk("off early", rd[3], 1'b0);
    cyc(60);
    apb(1'b0, prs_pkg::REG_STATUS, 32'h0);
    chk("status", rd, 32'hc);
    chk("irq set", irq, 1'b1);
    apb(1'b1, prs_pkg::REG_STATUS, 32'hf);
    chk("irq clear", irq, 1'b0);
    $display("test order %0d done", a);
  endtask : runSeq
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : conclude
  // ----------
  // Tests
  // ----------
  initial begin
    cyc(6);
    rst_n <= 1'b1;
    cyc(4);
    chk("rails reset", en, 5'h00);
    apb(1'b0, prs_pkg::REG_MASK, 32'h0);
    chk("mask reset", rd, 32'h0);
    apb(1'b0, prs_pkg::REG_STATE, 32'h0);
    chk("state idle", rd[3:0], prs_pkg::SQ_IDLE);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped err", rdErr, 1'b1);
    chk("unmapped data", rd, 32'h0);
    foreach (ordA[i]) begin
      {ldo, ob, oa, trig, en1} <= 5'h05 << i;
      cyc(6);
      chk("indep", en, 5'(5'h05 << i));
      chk("indep discharge", dis, 4'(~(5'h05 << i)));
    end
    {ldo, ob, oa, trig, en1} <= 5'h00;
    cyc(6);
    $display("test reset and independent done");
    runSeq(1'b1, ordA);
    runSeq(1'b0, ordB);
    for (int i = 0; i < 5; i++) begin
      {sel, oa, ob, trig, en1, ldo} <= 6'h03;
      cyc(6);
      pf[i] <= 1'b1;
      cyc(30);
      pf <= 5'h00;
      cyc(6);
      chk("short fault", sd, i == 4);
      pf[i] <= 1'b1;
      cyc(60);
      pf <= 5'h00;
      cyc(6);
      chk("shutdown", {sd, en}, 6'h20);
      chk("shutdown discharge", dis, 4'hf);
      {en1, ldo} <= 2'h0;
      cyc(8);
      chk("release", sd, 1'b0);
    end
    apb(1'b1, prs_pkg::REG_STATUS, 32'hf);
    {en1, ldo} <= 2'h3;
    battery_input <= 1'b1;
    cyc(8);
    chk("lockout", {sd, en}, 6'h00);
    battery_input <= 1'b0;
    cyc(8);
    chk("recover", en, 5'h11);
    apb(1'b0, prs_pkg::REG_STATUS, 32'h0);
    chk("uvlo event", rd[1], 1'b1);
    $display("test faults done");
    conclude();
  end
  initial begin
    cyc(20000);
    err_count++;
    conclude();
  end
endmodule : prs_sequencer_test
